// [design/fbep_consts.vh]
`ifndef FBEP_CONSTS_VH
`define FBEP_CONSTS_VH
// flash geometry, 32-bit words
`define FBEP_ADDR_W 12
`define FBEP_WORD_W 32
`define FBEP_NUM_WORDS 4096
`define FBEP_BLK_SHIFT 8
`define FBEP_BLK_W 4
`define FBEP_REG_SHIFT 9
`define FBEP_REG_W 3
`define FBEP_NUM_REGIONS 8
// protection states, two bits per region
`define FBEP_PROT_NONE 2'h0
`define FBEP_PROT_RO 2'h1
`define FBEP_PROT_XO 2'h2
`define FBEP_ERASED_WORD 32'hffffffff
`define FBEP_ZERO_WORD 32'h00000000
`define FBEP_ADDR_ZERO 12'h000
`define FBEP_WORD_STEP 8'h01
`define FBEP_WORD_LAST 8'hff
`define FBEP_WORD_FIRST 8'h00
`endif

// [design/fbep_flash.v]
// Functional notes
// - 16 KB array, single-cycle reads
// - 1 KB blocks erased independently
// - erased block reads all ones
// - protection per 2 KB region, a block pair
// - region states: none, read-only, execute-only
// - read-only refuses erase and program
// - execute-only serves instruction fetches only
`include "fbep_consts.vh"
module fbep_flash
#(
	parameter ADDR_W = `FBEP_ADDR_W,
	parameter DATA_W = `FBEP_WORD_W
)
(
	input wire clk,
	input wire rstn,
	// instruction fetch read port
	input wire fetch_req,
	input wire [ADDR_W-1:0] fetch_addr,
	output reg [DATA_W-1:0] fetch_rdata,
	output reg fetch_valid,
	// data and debugger read port
	input wire data_req,
	input wire [ADDR_W-1:0] data_addr,
	output reg [DATA_W-1:0] data_rdata,
	output reg data_valid,
	// word program, new word is old AND wdata
	input wire prog_req,
	input wire [ADDR_W-1:0] prog_addr,
	input wire [DATA_W-1:0] prog_wdata,
	// block erase
	input wire erase_req,
	input wire [`FBEP_BLK_W-1:0] erase_blk,
	// protection map write
	input wire prot_wr,
	input wire [`FBEP_REG_W-1:0] prot_region,
	input wire [1:0] prot_state,
	// sequencer status and sticky violation
	output reg busy_reg,
	output reg done_reg,
	output reg refused_reg,
	output reg viol_reg,
	input wire viol_clr,
	output reg [2*`FBEP_NUM_REGIONS-1:0] prot_map_reg
);
	// 4096 x 32-bit words form the 16 KB array
	reg [DATA_W-1:0] mem [0:`FBEP_NUM_WORDS-1];
	// one-hot sequencer states
	localparam ST_IDLE = 2'b01;
	localparam ST_ERASE = 2'b10;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	// block being erased and its word counter
	reg [`FBEP_BLK_W-1:0] eblk_reg;
	reg [`FBEP_BLK_SHIFT-1:0] ecnt_reg;
	// per-access protection results
	wire fetch_ok;
	wire data_ok;
	wire prog_ok;
	wire erase_ok;
	// state of the addressed region
	wire [1:0] fetch_prot;
	wire [1:0] data_prot;
	wire [1:0] prog_prot;
	wire [1:0] erase_prot;
	// request decode
	wire prog_go;
	wire erase_go;
	wire viol_event;
	wire idle;
	wire erase_last;
	wire modify_refused;
	// gated array read words
	wire [DATA_W-1:0] fetch_word;
	wire [DATA_W-1:0] data_word;

	// region index is address top bits, two blocks each
	assign fetch_prot = prot_map_reg[2*fetch_addr[ADDR_W-1:`FBEP_REG_SHIFT] +: 2];
	assign data_prot = prot_map_reg[2*data_addr[ADDR_W-1:`FBEP_REG_SHIFT] +: 2];
	assign prog_prot = prot_map_reg[2*prog_addr[ADDR_W-1:`FBEP_REG_SHIFT] +: 2];
	assign erase_prot = prot_map_reg[2*erase_blk[`FBEP_BLK_W-1:1] +: 2];

	fbep_prot_check u_chk_fetch
	(
		.prot(fetch_prot),
		.is_fetch(1'b1),
		.is_modify(1'b0),
		.allow(fetch_ok)
	);
	fbep_prot_check u_chk_data
	(
		.prot(data_prot),
		.is_fetch(1'b0),
		.is_modify(1'b0),
		.allow(data_ok)
	);
	fbep_prot_check u_chk_prog
	(
		.prot(prog_prot),
		.is_fetch(1'b0),
		.is_modify(1'b1),
		.allow(prog_ok)
	);
	fbep_prot_check u_chk_erase
	(
		.prot(erase_prot),
		.is_fetch(1'b0),
		.is_modify(1'b1),
		.allow(erase_ok)
	);

	// sequencer status shared by the control paths
	assign idle = (state_reg == ST_IDLE);
	assign erase_last = (state_reg == ST_ERASE) & (ecnt_reg == `FBEP_WORD_LAST);

	// modify requests are taken only while idle; program wins over erase
	assign prog_go = prog_req & idle & prog_ok;
	assign erase_go = erase_req & idle & ~prog_req & erase_ok;
	// the request that would have run is refused, array untouched
	assign modify_refused = idle & (prog_req ? ~prog_ok : (erase_req & ~erase_ok));
	// refused modify or data read is a violation
	assign viol_event = (data_req & ~data_ok) | modify_refused;

	// array read ports; a word stays hidden unless the access is allowed
	// execute-only hides data from data reads
	assign fetch_word = fetch_ok ? mem[fetch_addr] : `FBEP_ZERO_WORD;
	assign data_word = data_ok ? mem[data_addr] : `FBEP_ZERO_WORD;

	// next state
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (erase_go)
					state_next = ST_ERASE;
			end
			ST_ERASE:
			begin
				if (erase_last)
					state_next = ST_IDLE;
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	// reads answer on the next edge, no wait states
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			fetch_rdata <= `FBEP_ZERO_WORD;
			fetch_valid <= 1'b0;
			data_rdata <= `FBEP_ZERO_WORD;
			data_valid <= 1'b0;
		end
		else
		begin
			fetch_valid <= fetch_req;
			data_valid <= data_req;
			// rdata is zero between beats so stale words never linger
			fetch_rdata <= fetch_req ? fetch_word : `FBEP_ZERO_WORD;
			data_rdata <= data_req ? data_word : `FBEP_ZERO_WORD;
		end
	end

	// array writes: programming clears bits, erase sets block words
	// a reset during an erase leaves the block part erased; erase again
	// the array itself is never reset, its words are X until written
	always @(posedge clk)
	begin
		// erase writes all-ones word by word
		if (state_reg == ST_ERASE)
			mem[{eblk_reg, ecnt_reg}] <= `FBEP_ERASED_WORD;
		else if (prog_go)
			mem[prog_addr] <= mem[prog_addr] & prog_wdata;
	end

	// control, status and protection state
	always @(posedge clk)
	begin
		if (!rstn)
		begin
			state_reg <= ST_IDLE;
			eblk_reg <= {`FBEP_BLK_W{1'b0}};
			ecnt_reg <= `FBEP_WORD_FIRST;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
			viol_reg <= 1'b0;
			prot_map_reg <= {2*`FBEP_NUM_REGIONS{1'b0}};
		end
		else
		begin
			state_reg <= state_next;
			// erase touches only the selected block
			if (erase_go)
			begin
				eblk_reg <= erase_blk;
				ecnt_reg <= `FBEP_WORD_FIRST;
			end
			else if (state_reg == ST_ERASE)
				ecnt_reg <= ecnt_reg + `FBEP_WORD_STEP;
			// busy tracks the sequencer state it launches
			busy_reg <= (state_next == ST_ERASE);
			done_reg <= prog_go | erase_last;
			// refused modify is reported, array untouched
			refused_reg <= modify_refused;
			// sticky flag, set wins over clear
			if (viol_event)
				viol_reg <= 1'b1;
			else if (viol_clr)
				viol_reg <= 1'b0;
			// each region written independently
			// a running erase was checked at its start and is not stopped
			if (prot_wr)
				prot_map_reg[2*prot_region +: 2] <= prot_state;
		end
	end
endmodule // fbep_flash

// [design/fbep_prot_check.v]
`include "fbep_consts.vh"
// decides whether an access to one region is allowed
module fbep_prot_check
(
	input wire [1:0] prot,
	input wire is_fetch,
	input wire is_modify,
	output wire allow
);
	// modify needs unprotected; data read refused only for execute-only
	assign allow = is_modify ? (prot == `FBEP_PROT_NONE)
		: (is_fetch | (prot != `FBEP_PROT_XO));
endmodule // fbep_prot_check

// [testbench/fbep_checker.sv]
module fbep_checker
(
	input wire clk,
	input wire rstn,
	input wire fetch_req,
	input wire fetch_valid,
	input wire data_req,
	input wire data_valid,
	input wire prog_req,
	input wire busy_reg,
	input wire done_reg,
	input wire refused_reg,
	input wire viol_reg,
	input wire viol_clr,
	input wire prot_wr,
	input wire [11:0] data_addr,
	input wire [11:0] prog_addr,
	input wire [31:0] data_rdata,
	input wire [2:0] prot_region,
	input wire [1:0] prot_state,
	input wire [15:0] prot_map_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// state of the addressed region
	wire [1:0] pp = prot_map_reg[{prog_addr[11:9], 1'b0} +: 2];
	wire [1:0] dp = prot_map_reg[{data_addr[11:9], 1'b0} +: 2];
	AST_FV: assert property (fetch_req |=> fetch_valid) else $error("no fetch");
	AST_DV: assert property (data_req |=> data_valid) else $error("no read");
	AST_ER: assert property ($rose(busy_reg) |-> ##255 (busy_reg && !done_reg)
		##1 (done_reg && !busy_reg)) else $error("erase length");
	AST_PO: assert property (prog_req && !busy_reg && pp == 0 |=> done_reg)
		else $error("no program");
	AST_MP: assert property (prot_wr |=>
		prot_map_reg[{$past(prot_region), 1'b0} +: 2] == $past(prot_state)) else $error("map");
	AST_PR: assert property (prog_req && !busy_reg && pp != 0 |=> refused_reg && !done_reg)
		else $error("not refused");
	AST_XO: assert property (data_req && dp == 2 |=> data_rdata == 0 && viol_reg)
		else $error("data leak");
	AST_VI: assert property (refused_reg |-> viol_reg) else $error("no flag");
	AST_VS: assert property (viol_reg && !viol_clr |=> viol_reg) else $error("flag lost");
endmodule // fbep_checker
bind fbep_flash fbep_checker i_chk
(
	.clk(clk),
	.rstn(rstn),
	.fetch_req(fetch_req),
	.fetch_valid(fetch_valid),
	.data_req(data_req),
	.data_valid(data_valid),
	.prog_req(prog_req),
	.busy_reg(busy_reg),
	.done_reg(done_reg),
	.refused_reg(refused_reg),
	.viol_reg(viol_reg),
	.viol_clr(viol_clr),
	.prot_wr(prot_wr),
	.data_addr(data_addr),
	.prog_addr(prog_addr),
	.data_rdata(data_rdata),
	.prot_region(prot_region),
	.prot_state(prot_state),
	.prot_map_reg(prot_map_reg)
);

// [testbench/fbep_cpu.sv]
module fbep_cpu
(
	input wire clk,
	output logic fetch_req = 1'b0,
	output logic data_req = 1'b0,
	output logic [11:0] fetch_addr = 12'h000,
	output logic [11:0] data_addr = 12'h000
);
	timeunit 1ns;
	timeprecision 1ps;
	// one read beat; released address lines show the inverse
	task rd(input logic f, input logic [11:0] a);
		@(posedge clk);
		fetch_req <= f;
		data_req <= !f;
		fetch_addr <= f ? a : ~fetch_addr;
		data_addr <= f ? ~data_addr : a;
		@(posedge clk);
		fetch_req <= 0;
		data_req <= 0;
		fetch_addr <= ~fetch_addr;
		data_addr <= ~data_addr;
	endtask
endmodule // fbep_cpu

// [testbench/tb_top.sv]
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, prog_req = 0, erase_req = 0, prot_wr = 0, viol_clr = 0;
	logic [11:0] prog_addr = 0;
	logic [31:0] prog_wdata = 0, w, v, qf[$], qd[$];
	logic [3:0] erase_blk = 0;
	logic [2:0] prot_region = 0;
	logic [1:0] prot_state = 0;
	wire fetch_req, data_req, fetch_valid, data_valid, busy_reg, done_reg, refused_reg, viol_reg;
	wire [11:0] fetch_addr, data_addr;
	wire [31:0] fetch_rdata, data_rdata;
	wire [15:0] prot_map_reg;
	int n_fail = 0, compares = 0;
	always #2 clk = ~clk;
	fbep_cpu i_cpu
	(
		.clk(clk),
		.fetch_req(fetch_req),
		.data_req(data_req),
		.fetch_addr(fetch_addr),
		.data_addr(data_addr)
	);
	fbep_flash i_dut
	(
		.clk(clk),
		.rstn(rstn),
		.fetch_req(fetch_req),
		.fetch_addr(fetch_addr),
		.fetch_rdata(fetch_rdata),
		.fetch_valid(fetch_valid),
		.data_req(data_req),
		.data_addr(data_addr),
		.data_rdata(data_rdata),
		.data_valid(data_valid),
		.prog_req(prog_req),
		.prog_addr(prog_addr),
		.prog_wdata(prog_wdata),
		.erase_req(erase_req),
		.erase_blk(erase_blk),
		.prot_wr(prot_wr),
		.prot_region(prot_region),
		.prot_state(prot_state),
		.busy_reg(busy_reg),
		.done_reg(done_reg),
		.refused_reg(refused_reg),
		.viol_reg(viol_reg),
		.viol_clr(viol_clr),
		.prot_map_reg(prot_map_reg)
	);
	task chk(input logic [31:0] g, e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %0t mismatch got %h expected %h", $time, g, e);
		end
	endtask
	// one compare per kind of result
	task chk_rd(input logic [31:0] g, e);
		chk(g, e);
	endtask
	task chk_op(input logic [1:0] g, e);
		chk({30'h0, g}, {30'h0, e});
	endtask
	task chk_viol(input logic g, e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task close_out;
		// a read that never answered leaves its note behind
		if (qf.size() != 0 || qd.size() != 0)
			n_fail++;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// program (p) or erase, then done and refused flags
	task op(input logic p, input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk);
		prog_req <= p;
		erase_req <= !p;
		prog_addr <= a;
		erase_blk <= a[11:8];
		prog_wdata <= d;
		@(posedge clk);
		prog_req <= 0;
		erase_req <= 0;
		#1;
		for (int i = 0; i < 300 && busy_reg !== 0; i++)
			@(posedge clk) #1;
		chk_op({done_reg, refused_reg}, e);
	endtask
	task rd(input logic f, input logic [11:0] a, input logic [31:0] e);
		if (f)
			qf.push_back(e);
		else
			qd.push_back(e);
		i_cpu.rd(f, a);
	endtask
	task prot(input logic [2:0] r, input logic [1:0] s);
		@(posedge clk);
		prot_wr <= 1;
		prot_region <= r;
		prot_state <= s;
		@(posedge clk);
		prot_wr <= 0;
	endtask
	// read results against the oldest note
	always @(negedge clk)
	begin
		if (fetch_valid === 1)
			chk_rd(fetch_rdata, qf.pop_front());
		if (data_valid === 1)
			chk_rd(data_rdata, qd.pop_front());
	end
	initial
	begin
		#20000;
		n_fail++;
		close_out;
	end
	initial
	begin
		w = $urandom(32'h12fd);
		repeat (8) @(posedge clk);
		rstn <= 1;
		op(0, 12'h000, 32'h0, 2'h2);
		rd(1, 12'h000, 32'hffffffff);
		rd(0, 12'h0ff, 32'hffffffff);
		op(1, 12'h001, w, 2'h2);
		op(0, 12'h100, 32'h0, 2'h2);
		rd(0, 12'h001, w);
		prot(0, 1);
		op(0, 12'h000, 32'h0, 2'h1);
		rd(0, 12'h001, w);
		#1 chk_viol(viol_reg, 1'b1);
		@(posedge clk) viol_clr <= 1'b1;
		@(posedge clk) viol_clr <= 1'b0;
		#1 chk_viol(viol_reg, 1'b0);
		prot(0, 2);
		op(1, 12'h001, 32'h0, 2'h1);
		rd(1, 12'h001, w);
		rd(0, 12'h001, 32'h0);
		// a clear and a new violation in one cycle: the set wins
		fork
			rd(0, 12'h001, 32'h0);
			@(posedge clk) viol_clr <= 1'b1;
		join
		viol_clr <= 1'b0;
		#1 chk_viol(viol_reg, 1'b1);
		// region 1 stays writable while region 0 is execute-only
		v = $urandom;
		op(0, 12'h200, 32'h0, 2'h2);
		rd(0, 12'h2ff, 32'hffffffff);
		op(1, 12'h200, v, 2'h2);
		op(1, 12'h200, 32'hffff0000, 2'h2);
		rd(0, 12'h200, v & 32'hffff0000);
		// code 3 is readable but refuses erase and program
		prot(1, 3);
		op(0, 12'h300, 32'h0, 2'h1);
		op(1, 12'h200, 32'h0, 2'h1);
		rd(0, 12'h200, v & 32'hffff0000);
		rd(1, 12'h001, w);
		repeat (4) @(posedge clk);
		close_out;
	end
endmodule // tb_top
